// ---- include/irq_if.sv ----
// carrier between the register bank and its interrupt block
`timescale 1ns/1ns
interface irq_if;
  logic [1:0] events;
  logic clear_wr;
  logic enable_wr;
  logic [1:0] wdata;
  logic [1:0] status;
  logic [1:0] enable;
  logic irq;

  modport bank (output events, output clear_wr, output enable_wr, output wdata,
    input status, input enable, input irq);
  modport irq_block (input events, input clear_wr, input enable_wr, input wdata,
    output status, output enable, output irq);
endinterface

// ---- include/thermal_cfg.svh ----
// constants of the thermal status register bank
`ifndef THERMAL_CFG_SVH
`define THERMAL_CFG_SVH

// ************************************************
// register byte addresses
// ************************************************
`define ADDR_DEVICE_TYPE 12'h004
`define ADDR_CRIT_LOW_LOWER 12'h088
`define ADDR_CRIT_LOW_UPPER 12'h08c
`define ADDR_DEVICE_STATUS 12'h0c0
`define ADDR_TEMP_LOWER 12'h0c4
`define ADDR_TEMP_UPPER 12'h0c8
`define ADDR_IRQ_STATUS 12'h100
`define ADDR_IRQ_ENABLE 12'h104
`define ADDR_IRQ_CLEAR 12'h108

// ************************************************
// reset values and codes
// ************************************************
`define RST_DEVICE_TYPE 8'h00
`define RST_CRIT_LOW 8'h00
`define RST_TEMP 16'h0000
`define THERMAL_PRESENT_CODE 8'h18

// ************************************************
// field positions
// ************************************************
`define STATUS_IRQ_BIT 7
`define STATUS_WRITE_BIT 3
`define STATUS_OVERRIDE_BIT 2
`define EVT_CONVERSION_BIT 0
`define EVT_WRITE_DONE_BIT 1
`define EVT_WIDTH 2

// ************************************************
// timing
// ************************************************
`define STRAP_SETTLE_CYCLES 2'h2

`endif

// ---- include/thermal_pkg.sv ----
// types of the thermal status register bank
package thermal_pkg;

  typedef enum logic [1:0] {
    STRAP_WAIT = 2'b00,
    STRAP_SETTLE = 2'b01,
    STRAP_DONE = 2'b10
  } strap_state_t;

  typedef struct packed {
    logic [7:0] device_type_selection;
    logic [7:0] critical_low_limit_lower_byte;
    logic [7:0] critical_low_limit_upper;
    logic [15:0] sensed_temperature;
    logic strap_sync1;
    logic strap_sync2;
    strap_state_t strap_state;
    logic [1:0] strap_count;
    logic override_allowed;
    logic write_busy_prev;
    logic [31:0] prdata;
  } bank_state_t;

  typedef struct packed {
    logic [1:0] status;
    logic [1:0] enable;
  } irq_state_t;

endpackage

// ---- logic/event_irq.sv ----
// sticky event status, enable mask and level interrupt
`timescale 1ns/1ns
module event_irq
  import thermal_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bank side
  irq_if.irq_block ctl
);

  irq_state_t st;
  irq_state_t next_st;

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    next_st = st;
    // set wins over a clear in the same cycle
    if (ctl.clear_wr) begin
      next_st.status = (st.status & ~ctl.wdata) | ctl.events;
    end else begin
      next_st.status = st.status | ctl.events;
    end
    if (ctl.enable_wr) begin
      next_st.enable = ctl.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ctl.status = st.status;
  assign ctl.enable = st.enable;
  assign ctl.irq = |(st.status & st.enable);

endmodule

// ---- logic/thermal_status_register_bank.sv ----
// apb register bank: critical low limit, device status and sensed temperature
`timescale 1ns/1ns
`include "thermal_cfg.svh"
module thermal_status_register_bank
  import thermal_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // sensor and storage engine
  input wire logic conversion_valid,
  input wire logic [15:0] conversion_data,
  input wire logic internal_write_busy,
  // strap sense, high when the pin is tied straight to ground
  input wire logic address_strap_pin,
  // interrupt
  output logic irq
);

  bank_state_t st;
  bank_state_t next_st;
  irq_if ctl ();

  logic thermal_on;
  logic setup_phase;
  logic access_write;
  logic write_allowed;
  logic [7:0] device_status;
  logic conversion_take;

  // ************************************************
  // address decode
  // ************************************************
  function automatic logic is_mapped(input logic [11:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr == `ADDR_DEVICE_TYPE) begin
      hit = 1'b1;
    end else if (addr == `ADDR_CRIT_LOW_LOWER) begin
      hit = 1'b1;
    end else if (addr == `ADDR_CRIT_LOW_UPPER) begin
      hit = 1'b1;
    end else if (addr == `ADDR_DEVICE_STATUS) begin
      hit = 1'b1;
    end else if (addr == `ADDR_TEMP_LOWER) begin
      hit = 1'b1;
    end else if (addr == `ADDR_TEMP_UPPER) begin
      hit = 1'b1;
    end else if (addr == `ADDR_IRQ_STATUS) begin
      hit = 1'b1;
    end else if (addr == `ADDR_IRQ_ENABLE) begin
      hit = 1'b1;
    end else if (addr == `ADDR_IRQ_CLEAR) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic logic is_write(input logic [11:0] addr, input logic [11:0] target);
    return access_write && write_allowed && pstrb[0] && (addr == target);
  endfunction

  // ************************************************
  // status and gating
  // ************************************************
  assign thermal_on = (st.device_type_selection == `THERMAL_PRESENT_CODE);
  assign setup_phase = psel && !penable;
  assign access_write = psel && penable && pwrite;
  // no wait states, so a busy engine cannot stall the bus; the write is dropped
  assign write_allowed = !internal_write_busy;
  // the capture is gated too, so stale data is not shown once enabled
  assign conversion_take = conversion_valid && thermal_on;

  always_comb begin
    device_status = 8'h00;
    device_status[`STATUS_IRQ_BIT] = ctl.irq;
    device_status[`STATUS_WRITE_BIT] = internal_write_busy;
    device_status[`STATUS_OVERRIDE_BIT] = st.override_allowed;
  end

  // ************************************************
  // interrupt block
  // ************************************************
  always_comb begin
    ctl.events = '0;
    ctl.events[`EVT_CONVERSION_BIT] = conversion_take;
    ctl.events[`EVT_WRITE_DONE_BIT] = st.write_busy_prev && !internal_write_busy;
    ctl.clear_wr = is_write(paddr, `ADDR_IRQ_CLEAR);
    ctl.enable_wr = is_write(paddr, `ADDR_IRQ_ENABLE);
    ctl.wdata = pwdata[`EVT_WIDTH-1:0];
  end

  event_irq u_event_irq (
    .pclk(pclk),
    .presetn(presetn),
    .ctl(ctl)
  );

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    next_st = st;

    // two-flop synchroniser; the first stage feeds only the second
    next_st.strap_sync1 = address_strap_pin;
    next_st.strap_sync2 = st.strap_sync1;

    // strap caught once after reset release, never again
    case (st.strap_state)
      STRAP_WAIT: begin
        next_st.strap_count = 2'h0;
        next_st.strap_state = STRAP_SETTLE;
      end
      STRAP_SETTLE: begin
        if (st.strap_count == `STRAP_SETTLE_CYCLES) begin
          next_st.override_allowed = st.strap_sync2;
          next_st.strap_state = STRAP_DONE;
        end else begin
          next_st.strap_count = st.strap_count + 2'h1;
        end
      end
      STRAP_DONE: begin
        next_st.strap_state = STRAP_DONE;
      end
      default: begin
        next_st.strap_state = STRAP_WAIT;
      end
    endcase

    next_st.write_busy_prev = internal_write_busy;

    // whole word captured in one edge
    if (conversion_take) begin
      next_st.sensed_temperature = conversion_data;
    end

    // register writes, low byte lane only
    if (is_write(paddr, `ADDR_DEVICE_TYPE)) begin
      next_st.device_type_selection = pwdata[7:0];
    end
    if (is_write(paddr, `ADDR_CRIT_LOW_LOWER) && thermal_on) begin
      next_st.critical_low_limit_lower_byte = pwdata[7:0];
    end
    if (is_write(paddr, `ADDR_CRIT_LOW_UPPER) && thermal_on) begin
      next_st.critical_low_limit_upper = pwdata[7:0];
    end

    // read data prepared in the setup cycle, shown in the access cycle
    if (setup_phase && !pwrite) begin
      next_st.prdata = 32'h0000_0000;
      if (paddr == `ADDR_DEVICE_TYPE) begin
        next_st.prdata[7:0] = st.device_type_selection;
      end else if (paddr == `ADDR_CRIT_LOW_LOWER && thermal_on) begin
        next_st.prdata[7:0] = st.critical_low_limit_lower_byte;
      end else if (paddr == `ADDR_CRIT_LOW_UPPER && thermal_on) begin
        next_st.prdata[7:0] = st.critical_low_limit_upper;
      end else if (paddr == `ADDR_DEVICE_STATUS) begin
        next_st.prdata[7:0] = device_status;
      end else if (paddr == `ADDR_TEMP_LOWER && thermal_on) begin
        next_st.prdata[7:0] = st.sensed_temperature[7:0];
      end else if (paddr == `ADDR_TEMP_UPPER && thermal_on) begin
        next_st.prdata[7:0] = st.sensed_temperature[15:8];
      end else if (paddr == `ADDR_IRQ_STATUS) begin
        next_st.prdata[`EVT_WIDTH-1:0] = ctl.status;
      end else if (paddr == `ADDR_IRQ_ENABLE) begin
        next_st.prdata[`EVT_WIDTH-1:0] = ctl.enable;
      end
    end
  end

  // ************************************************
  // state register
  // ************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.device_type_selection <= `RST_DEVICE_TYPE;
      st.critical_low_limit_lower_byte <= `RST_CRIT_LOW;
      st.critical_low_limit_upper <= `RST_CRIT_LOW;
      st.sensed_temperature <= `RST_TEMP;
      st.strap_sync1 <= 1'b0;
      st.strap_sync2 <= 1'b0;
      st.strap_state <= STRAP_WAIT;
      st.strap_count <= 2'h0;
      st.override_allowed <= 1'b0;
      st.write_busy_prev <= 1'b0;
      st.prdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign prdata = st.prdata;
  assign irq = ctl.irq;

endmodule

// ---- tb/sensor_engine_model.sv ----
// behavioural sensor and storage engine feeding the register bank
`timescale 1ns/1ns
module sensor_engine_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench commands
  input wire logic conv_req,
  input wire logic [15:0] conv_value,
  input wire logic write_req,
  input wire logic [3:0] write_cycles,
  // towards the bank
  output logic conversion_valid,
  output logic [15:0] conversion_data,
  output logic internal_write_busy
);
  logic [3:0] left;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_valid <= 1'b0;
      conversion_data <= 16'h0000;
      left <= 4'h0;
    end else begin
      conversion_valid <= conv_req;
      // data is not held outside the pulse
      conversion_data <= conv_req ? conv_value : ~conversion_data;
      left <= write_req ? write_cycles : left - {3'h0, left != 4'h0};
    end
  end
  assign internal_write_busy = left != 4'h0;
endmodule

// ---- tb/test_thermal_status_register_bank.sv ----
// self-checking bench of the thermal register bank
`timescale 1ns/1ns
`include "thermal_cfg.svh"
module test_thermal_status_register_bank;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic conv_req, write_req, conversion_valid, internal_write_busy, address_strap_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] pstrb;
  logic [15:0] conv_value, conversion_data;
  int miscompares, comparisons, cycles;
  thermal_status_register_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .conversion_valid(conversion_valid),
    .conversion_data(conversion_data), .internal_write_busy(internal_write_busy),
    .address_strap_pin(address_strap_pin), .irq(irq));
  sensor_engine_model u_engine (.pclk(pclk), .presetn(presetn), .conv_req(conv_req),
    .conv_value(conv_value), .write_req(write_req), .write_cycles(4'hc),
    .conversion_valid(conversion_valid), .conversion_data(conversion_data),
    .internal_write_busy(internal_write_busy));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // bound on the whole run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      $display("mismatch at %0t: run did not finish", $time);
      stop_test();
    end
  end
  task stop_test;
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rdata, e);
  endtask
  task irq_is(input logic e);
    @(posedge pclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task convert(input logic [15:0] v);
    @(posedge pclk);
    conv_req <= 1'b1;
    conv_value <= v;
    @(posedge pclk);
    conv_req <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // strap moves only with reset, as a real pin would
  task reset_dut(input logic s);
    address_strap_pin <= s;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask
  initial begin
    {psel, penable, pwrite, conv_req, write_req} = 5'h00;
    {paddr, pwdata, pstrb, conv_value} = 64'h0;
    presetn = 1'b0;
    address_strap_pin = 1'b1;
    reset_dut(1'b1);
    rd(`ADDR_DEVICE_STATUS, 32'h04);
    wr(`ADDR_CRIT_LOW_UPPER, 32'ha5);
    rd(`ADDR_CRIT_LOW_UPPER, 32'h00);
    convert(16'h1234);
    rd(`ADDR_TEMP_LOWER, 32'h00);
    wr(`ADDR_DEVICE_TYPE, 32'h18);
    rd(`ADDR_TEMP_LOWER, 32'h00);
    wr(`ADDR_CRIT_LOW_LOWER, 32'h5a);
    rd(`ADDR_CRIT_LOW_LOWER, 32'h5a);
    wr(`ADDR_CRIT_LOW_UPPER, 32'ha5);
    apb(1'b1, `ADDR_CRIT_LOW_UPPER, 32'h3c, 4'h0);
    rd(`ADDR_CRIT_LOW_UPPER, 32'ha5);
    wr(`ADDR_DEVICE_STATUS, 32'h88);
    rd(`ADDR_DEVICE_STATUS, 32'h04);
    wr(`ADDR_IRQ_CLEAR, 32'h3);
    wr(`ADDR_IRQ_ENABLE, 32'h1);
    rd(`ADDR_IRQ_ENABLE, 32'h1);
    convert(16'h1234);
    rd(`ADDR_TEMP_LOWER, 32'h34);
    rd(`ADDR_TEMP_UPPER, 32'h12);
    rd(`ADDR_DEVICE_STATUS, 32'h84);
    irq_is(1'b1);
    wr(`ADDR_IRQ_CLEAR, 32'h3);
    irq_is(1'b0);
    wr(`ADDR_IRQ_ENABLE, 32'h0);
    convert(16'habcd);
    irq_is(1'b0);
    rd(`ADDR_TEMP_LOWER, 32'hcd);
    rd(`ADDR_TEMP_UPPER, 32'hab);
    @(posedge pclk);
    write_req <= 1'b1;
    @(posedge pclk);
    write_req <= 1'b0;
    rd(`ADDR_DEVICE_STATUS, 32'h0c);
    wr(`ADDR_CRIT_LOW_UPPER, 32'h77);
    rd(`ADDR_CRIT_LOW_UPPER, 32'ha5);
    repeat (20) if (internal_write_busy === 1'b1) @(posedge pclk);
    rd(`ADDR_DEVICE_STATUS, 32'h04);
    rd(`ADDR_IRQ_STATUS, 32'h3);
    rd(12'h200, 32'h0);
    chk({31'h0, err}, 32'h1);
    reset_dut(1'b0);
    rd(`ADDR_DEVICE_STATUS, 32'h00);
    wr(`ADDR_DEVICE_TYPE, 32'h18);
    rd(`ADDR_TEMP_LOWER, 32'h00);
    rd(`ADDR_TEMP_UPPER, 32'h00);
    stop_test();
  end
endmodule

// ---- tb/thermal_bank_properties.sv ----
// assertions on the ports of the thermal register bank
`timescale 1ns/1ns
`include "thermal_cfg.svh"
module thermal_bank_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // engine and interrupt
  input wire logic conversion_valid,
  input wire logic internal_write_busy,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_setup;
  logic st_setup;
  logic clr_all;
  assign rd_setup = psel && !penable && !pwrite;
  assign st_setup = rd_setup && paddr == `ADDR_DEVICE_STATUS;
  assign clr_all = psel && penable && pwrite && paddr == `ADDR_IRQ_CLEAR && pstrb[0];
  a_no_wait: assert property (psel && penable |-> pready)
    else $error("wait state seen");
  a_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_status_busy: assert property (st_setup |=> prdata[3] == $past(internal_write_busy))
    else $error("busy bit wrong");
  a_status_irq: assert property (st_setup |=> prdata[7] == $past(irq))
    else $error("pending bit wrong");
  a_status_rsvd: assert property (st_setup |=> prdata[6:4] == 3'h0 && prdata[1:0] == 2'h0)
    else $error("status reserved bits set");
  a_clear_drops: assert property (clr_all && pwdata[1:0] == 2'h3 && !internal_write_busy &&
    !$past(internal_write_busy) && !conversion_valid |=> !irq)
    else $error("irq after full clear");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  a_err_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_prdata_hold: assert property (!rd_setup |=> $stable(prdata))
    else $error("read data moved");
endmodule
bind thermal_status_register_bank thermal_bank_properties u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .conversion_valid(conversion_valid), .internal_write_busy(internal_write_busy), .irq(irq));
